//--- hdl/urt_pkg.sv
// urt_pkg: register map, field layout, reset values and mode encodings
// for the rate and timing register block of a serial transceiver channel.
// assumes a 32-bit avalon-mm register bus with word addressing in bytes.
package urt_pkg;
	// register byte offsets
	localparam logic [5:0] OFS_BAUD = 6'h00;
	localparam logic [5:0] OFS_RTO = 6'h04;
	localparam logic [5:0] OFS_GUARD = 6'h08;
	localparam logic [5:0] OFS_RATIO = 6'h0c;
	localparam logic [5:0] OFS_ERRCNT = 6'h10;
	localparam logic [5:0] OFS_IRF = 6'h14;
	localparam logic [5:0] OFS_MODE = 6'h18;
	localparam logic [5:0] OFS_CMD = 6'h1c;
	localparam logic [5:0] OFS_STAT = 6'h20;
	localparam logic [5:0] OFS_MASK = 6'h24;
	// field positions
	localparam int DIV_LSB = 0;
	localparam int DIV_W = 16;
	localparam int FRAC_LSB = 16;
	localparam int FRAC_W = 3;
	localparam int RATIO_W = 11;
	localparam int TALLY_W = 8;
	localparam int IRF_W = 8;
	localparam int GAP_W = 8;
	localparam int IDLE_W = 16;
	// mode register bits
	localparam int MODE_SYNC = 0;
	localparam int MODE_OVER = 1;
	localparam int MODE_CARD = 2;
	// command register bits
	localparam int CMD_ARM = 0;
	// status and mask bits
	localparam int ST_TIMEOUT = 0;
	localparam int ST_TALLY_OVF = 1;
	localparam int ST_W = 2;
	// reset values
	localparam logic [RATIO_W-1:0] RATIO_RST = 11'h174;
	// oversample factors, expressed as eighth-steps per bit
	localparam logic [7:0] EIGHTHS_X16 = 8'h80;
	localparam logic [7:0] EIGHTHS_X8 = 8'h40;
	localparam logic [7:0] EIGHTHS_X1 = 8'h08;
	// bus answer for unmapped reads
	localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
	// delimiter codes sent ahead of a character
	typedef enum logic [1:0] {
		URT_DELIM_DATA = 2'b01,
		URT_DELIM_CMD = 2'b10
	} urt_delim_t;
	// timeout machine, gray coded
	typedef enum logic [1:0] {
		URT_TO_IDLE = 2'b00,
		URT_TO_RUN = 2'b01,
		URT_TO_DONE = 2'b11
	} urt_to_state_t;
endpackage

//--- hdl/urt_tick_div.sv
// urt_tick_div: fractional tick divider. emits a one-cycle pulse every
// (divisor + frac/8) * factor/8 input tick periods; factor is in eighths.
// assumes in_tick is a one-cycle strobe on clk.
`timescale 1ns/1ps
`default_nettype none
module urt_tick_div #(
	parameter int DW = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// settings
	input wire logic [DW-1:0] divisor,
	input wire logic [2:0] frac,
	input wire logic [7:0] factor,
	input wire logic in_tick,
	// output strobe
	output logic out_tick
);
	// period in eighths of input ticks = factor*(8*divisor+frac)/8; sized wide to avoid overflow
	logic [DW+12:0] base8;
	logic [DW+12:0] prod;
	logic [DW+12:0] period;
	assign base8 = {10'h0, divisor, 3'h0} + (DW+13)'(frac);
	assign prod = base8 * {(DW+5)'(0), factor};
	assign period = prod >> 3;
	// compare in eighth units: each input tick adds 8 eighths
	logic [DW+15:0] acc8;
	logic [DW+15:0] sum8;
	logic [DW+15:0] per8;
	logic [DW+15:0] rem8;
	logic hit;
	assign sum8 = acc8 + (DW+16)'(8);
	assign per8 = (DW+16)'(period);
	assign rem8 = sum8 - per8;
	assign hit = in_tick && (sum8 >= per8);
	// a leftover equal to or larger than the new period (after a rate change) restarts at zero
	always_ff @(posedge clk) begin
		if (!reset_n || divisor == '0) begin
			acc8 <= '0;
			out_tick <= 1'b0;
		end else begin
			out_tick <= hit;
			if (hit)
				acc8 <= (rem8 >= per8) ? '0 : rem8;
			else if (in_tick)
				acc8 <= sum8;
		end
	end
	chk_zero_silent: assert property (@(posedge clk) disable iff (!reset_n)
		divisor == '0 |=> !out_tick) else $error("tick with zero divisor");
endmodule
`default_nettype wire

//--- hdl/urt_rate_regs.sv
// urt_rate_regs: baud generation, receive time-out, transmit timeguard,
// smart-card ratio, error tally, infrared filter and delimiter choice.
// Function
// - command flag 1 sends command delimiter, 0 sends data delimiter
// - async non-card baud is clock/16/divisor, or /8/divisor when oversample set
// - sync baud is clock/divisor; divisor zero stops the baud clock
// - fraction step zero disables fraction; 1..7 add step eighths to divisor
// - idle limit zero disables time-out; else delay is limit bit periods
// - gap zero inserts no guard; 1..255 insert gap bit periods
// - card mode baud is external clock divided by rate ratio
// - card mode ratio zero yields no baud clock at all
// - every card transfer error increments the error tally, which holds at 255
// - reading the tally returns the count and clears it
// - filter value sets the infrared receive demodulator filter
// - time-out flag sets after idle delay from arm; stays clear if limit zero
// assumes avalon-mm master, card clock and error strobes synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module urt_rate_regs
	import urt_pkg::*;
#(
	parameter int GUARD_W = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// avalon-mm slave
	input wire logic [5:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	// transceiver side
	input wire logic card_clk_tick,
	input wire logic card_error,
	input wire logic char_load,
	input wire logic char_cmd_flag,
	input wire logic rx_activity,
	input wire logic tx_char_done,
	// generated timing
	output logic baud_tick,
	output logic bit_tick,
	output logic [1:0] delim_code,
	output logic tx_hold,
	output logic [urt_pkg::IRF_W-1:0] ir_filter,
	output logic irq
);
	// configuration registers
	logic [DIV_W-1:0] baud_divisor;
	logic [FRAC_W-1:0] fraction_step;
	logic [IDLE_W-1:0] rx_idle_limit;
	logic [GAP_W-1:0] tx_gap_value;
	logic [RATIO_W-1:0] smartcard_rate_ratio;
	logic [TALLY_W-1:0] error_tally;
	logic [2:0] mode;
	logic [ST_W-1:0] status;
	logic [ST_W-1:0] mask;
	urt_to_state_t to_state;
	logic [IDLE_W-1:0] idle_cnt;
	logic [GAP_W-1:0] gap_cnt;
	logic ack;

	// bus decode; one wait cycle then acknowledge, so reads see settled state
	wire req = read || write;
	wire wr_go = write && ack;
	wire rd_go = read && ack;
	wire w_lo = byteenable[0];
	wire w_b1 = byteenable[1];
	wire w_b2 = byteenable[2];
	wire wr_baud = wr_go && address == OFS_BAUD;
	wire wr_rto = wr_go && address == OFS_RTO;
	wire wr_guard = wr_go && address == OFS_GUARD;
	wire wr_ratio = wr_go && address == OFS_RATIO;
	wire wr_irf = wr_go && address == OFS_IRF && w_lo;
	wire wr_mode = wr_go && address == OFS_MODE && w_lo;
	wire wr_cmd = wr_go && address == OFS_CMD && w_lo;
	wire wr_stat = wr_go && address == OFS_STAT && w_lo;
	wire wr_mask = wr_go && address == OFS_MASK && w_lo;
	wire rd_tally = rd_go && address == OFS_ERRCNT;
	wire card_mode = mode[MODE_CARD];
	wire sync_mode = mode[MODE_SYNC];

	// read mux; reserved and unmapped bits read zero
	logic [31:0] rd_mux;
	always_comb begin
		case (address)
			OFS_BAUD: rd_mux = {13'h0, fraction_step, baud_divisor};
			OFS_RTO: rd_mux = {16'h0, rx_idle_limit};
			OFS_GUARD: rd_mux = {24'h0, tx_gap_value};
			OFS_RATIO: rd_mux = {21'h0, smartcard_rate_ratio};
			OFS_ERRCNT: rd_mux = {24'h0, error_tally};
			OFS_IRF: rd_mux = {24'h0, ir_filter};
			OFS_MODE: rd_mux = {29'h0, mode};
			OFS_STAT: rd_mux = {30'h0, status};
			OFS_MASK: rd_mux = {30'h0, mask};
			default: rd_mux = UNMAPPED_DATA;
		endcase
	end

	// handshake: waitrequest high until the acknowledge cycle
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			ack <= 1'b0;
			readdata <= '0;
		end else begin
			ack <= req && !ack;
			if (req && !ack)
				readdata <= rd_mux;
		end
	end
	assign waitrequest = !ack;

	// configuration write path; 16-bit fields honour byte lanes
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			baud_divisor <= '0;
			fraction_step <= '0;
			rx_idle_limit <= '0;
			tx_gap_value <= '0;
			smartcard_rate_ratio <= RATIO_RST;
			ir_filter <= '0;
			mode <= '0;
			mask <= '0;
		end else begin
			if (wr_baud && w_lo) baud_divisor[7:0] <= writedata[7:0];
			if (wr_baud && w_b1) baud_divisor[15:8] <= writedata[15:8];
			if (wr_baud && w_b2) fraction_step <= writedata[FRAC_LSB+:FRAC_W];
			if (wr_rto && w_lo) rx_idle_limit[7:0] <= writedata[7:0];
			if (wr_rto && w_b1) rx_idle_limit[15:8] <= writedata[15:8];
			if (wr_guard && w_lo) tx_gap_value <= writedata[GAP_W-1:0];
			if (wr_ratio && w_lo) smartcard_rate_ratio[7:0] <= writedata[7:0];
			if (wr_ratio && w_b1) smartcard_rate_ratio[10:8] <= writedata[10:8];
			if (wr_irf) ir_filter <= writedata[IRF_W-1:0];
			if (wr_mode) mode <= writedata[2:0];
			if (wr_mask) mask <= writedata[ST_W-1:0];
		end
	end

	// baud generation; card mode divides the external clock by the ratio
	wire [DIV_W-1:0] gen_div = card_mode ? DIV_W'(smartcard_rate_ratio) : baud_divisor;
	wire [2:0] gen_frac = card_mode ? 3'h0 : fraction_step;
	wire [7:0] gen_factor = (card_mode || sync_mode) ? EIGHTHS_X1 :
		(mode[MODE_OVER] ? EIGHTHS_X8 : EIGHTHS_X16);
	wire gen_in = card_mode ? card_clk_tick : 1'b1;
	logic gen_tick;
	urt_tick_div #(.DW(DIV_W)) u_div (
		.clk(clk),
		.reset_n(reset_n),
		.divisor(gen_div), // zero divisor or ratio stops the generator
		.frac(gen_frac),
		.factor(gen_factor),
		.in_tick(gen_in),
		.out_tick(gen_tick)
	);
	// baud_tick and bit_tick both registered; bit period is one baud tick
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			baud_tick <= 1'b0;
			bit_tick <= 1'b0;
		end else begin
			baud_tick <= gen_tick;
			bit_tick <= gen_tick;
		end
	end

	// delimiter choice latched with each character
	always_ff @(posedge clk) begin
		if (!reset_n)
			delim_code <= URT_DELIM_DATA;
		else if (char_load)
			delim_code <= char_cmd_flag ? URT_DELIM_CMD : URT_DELIM_DATA;
	end

	// receiver time-out: counts bit periods of quiet line after arming
	wire arm = wr_cmd && writedata[CMD_ARM];
	wire to_fire = to_state == URT_TO_RUN && gen_tick && !rx_activity &&
		idle_cnt == rx_idle_limit - 16'h1;
	always_ff @(posedge clk) begin
		if (!reset_n || rx_idle_limit == '0) begin
			to_state <= URT_TO_IDLE;
			idle_cnt <= '0;
		end else begin
			case (to_state)
				URT_TO_IDLE: begin
					idle_cnt <= '0;
					if (arm) to_state <= URT_TO_RUN;
				end
				URT_TO_RUN: begin
					if (arm || rx_activity) idle_cnt <= '0;
					else if (to_fire) to_state <= URT_TO_DONE;
					else if (gen_tick) idle_cnt <= idle_cnt + 16'h1;
				end
				URT_TO_DONE: begin
					idle_cnt <= '0;
					if (arm) to_state <= URT_TO_RUN;
				end
				default: to_state <= URT_TO_IDLE;
			endcase
		end
	end

	// transmit timeguard: hold transmitter for gap bit periods after a char
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			gap_cnt <= '0;
			tx_hold <= 1'b0;
		end else if (tx_char_done && tx_gap_value != '0) begin
			gap_cnt <= tx_gap_value;
			tx_hold <= 1'b1;
		end else if (gen_tick && gap_cnt != '0) begin
			gap_cnt <= gap_cnt - 8'h1;
			tx_hold <= gap_cnt != 8'h1;
		end
	end

	// error tally; an error in the clearing read cycle survives as one count
	always_ff @(posedge clk) begin
		if (!reset_n)
			error_tally <= '0;
		else if (rd_tally)
			error_tally <= {7'h0, card_mode && card_error};
		else if (card_mode && card_error && error_tally != 8'hff)
			error_tally <= error_tally + 8'h1;
	end

	// sticky status; set beats write-one-to-clear
	wire [ST_W-1:0] st_set = {card_mode && card_error && error_tally == 8'hff, to_fire};
	wire [ST_W-1:0] st_clr = wr_stat ? writedata[ST_W-1:0] : '0;
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			status <= '0;
			irq <= 1'b0;
		end else begin
			status <= (status & ~st_clr) | st_set;
			irq <= |(((status & ~st_clr) | st_set) & mask);
		end
	end

	// checks
	chk_zero_limit_quiet: assert property (@(posedge clk) disable iff (!reset_n)
		rx_idle_limit == '0 && !status[ST_TIMEOUT] |=> !status[ST_TIMEOUT])
		else $error("timeout with zero limit");
	chk_tally_clear: assert property (@(posedge clk) disable iff (!reset_n)
		rd_tally && !card_error |=> error_tally == '0) else $error("tally kept");
	chk_tally_count: assert property (@(posedge clk) disable iff (!reset_n)
		card_mode && card_error && !rd_tally && error_tally < 8'hff
		|=> error_tally == $past(error_tally) + 8'h1) else $error("tally miss");
	chk_delim_cmd: assert property (@(posedge clk) disable iff (!reset_n)
		char_load |=> delim_code == ($past(char_cmd_flag) ? URT_DELIM_CMD : URT_DELIM_DATA))
		else $error("wrong delimiter");
	chk_gap_none: assert property (@(posedge clk) disable iff (!reset_n)
		tx_gap_value == '0 && !tx_hold |=> !tx_hold) else $error("guard without gap");
	chk_card_zero: assert property (@(posedge clk) disable iff (!reset_n)
		card_mode && smartcard_rate_ratio == '0 ##1 card_mode && smartcard_rate_ratio == '0
		|=> !baud_tick) else $error("card tick with zero ratio");
	chk_div_zero: assert property (@(posedge clk) disable iff (!reset_n)
		!card_mode && baud_divisor == '0 ##1 !card_mode && baud_divisor == '0
		|=> !baud_tick) else $error("tick with zero divisor");
	chk_filter_write: assert property (@(posedge clk) disable iff (!reset_n)
		wr_irf |=> ir_filter == $past(writedata[IRF_W-1:0])) else $error("filter lost");
	chk_bus_ack: assert property (@(posedge clk) disable iff (!reset_n)
		req && waitrequest |=> !waitrequest) else $error("slow ack");
	cov_timeout: cover property (@(posedge clk) to_fire);
	cov_tally_read: cover property (@(posedge clk) rd_tally && error_tally != '0);
	cov_guard: cover property (@(posedge clk) tx_hold ##1 !tx_hold);
endmodule
`default_nettype wire

//--- dv/urt_far_end.sv
// urt_far_end: behavioural far end of the line: card clock, card errors,
// character traffic toward the transmitter and receive line activity.
// assumes everything is synchronous to clk; the bench calls the tasks.
`timescale 1ns/1ps
`default_nettype none
module urt_far_end (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// card clock gate from the bench
	input wire logic card_run,
	// toward the block
	output logic card_clk_tick,
	output logic card_error,
	output logic char_load,
	output logic char_cmd_flag,
	output logic rx_activity,
	output logic tx_char_done
);
	logic half;
	// card clock edge every second cycle, still outside a card frame
	always_ff @(posedge clk) begin
		half <= reset_n & card_run & ~half;
	end
	assign card_clk_tick = half;
	// quiet line at time zero
	initial begin
		card_error = 1'b0;
		char_load = 1'b0;
		char_cmd_flag = 1'b0;
		rx_activity = 1'b0;
		tx_char_done = 1'b0;
	end
	// one-cycle error pulses, a gap between them so none merge
	task send_errors(input int n);
		repeat (n) begin
			@(posedge clk) card_error <= 1'b1;
			@(posedge clk) card_error <= 1'b0;
		end
	endtask
	// the flag is only meaningful with the load strobe, so invert it after
	task load_char(input logic f);
		@(posedge clk) begin
			char_load <= 1'b1;
			char_cmd_flag <= f;
		end
		@(posedge clk) begin
			char_load <= 1'b0;
			char_cmd_flag <= ~f;
		end
	endtask
	task end_char();
		@(posedge clk) tx_char_done <= 1'b1;
		@(posedge clk) tx_char_done <= 1'b0;
	endtask
endmodule
`default_nettype wire

//--- dv/testbench.sv
// testbench: register access, rate, timing and tally checks of urt_rate_regs.
// assumes the avalon-mm slave answers with one wait cycle per request.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import urt_pkg::*;
	logic clk, reset_n, read, write, card_run;
	logic [5:0] address;
	logic [31:0] writedata, readdata, rdata;
	logic [3:0] byteenable;
	logic waitrequest, card_clk_tick, card_error, char_load, char_cmd_flag;
	logic rx_activity, tx_char_done, baud_tick, bit_tick, tx_hold, irq;
	logic [1:0] delim_code;
	logic [7:0] ir_filter;
	logic [31:0] p;
	int fails = 0;
	int total_checks = 0;
	int n;
	// field width table: offset and the bits that survive an all-ones write
	logic [5:0] wofs[5] = '{OFS_BAUD, OFS_RTO, OFS_GUARD, OFS_RATIO, OFS_IRF};
	logic [31:0] wexp[5] = '{32'h7ffff, 32'hffff, 32'hff, 32'h7ff, 32'hff};
	// rate table: mode, baud register, expected tick period in clocks
	logic [31:0] rmode[5] = '{32'h1, 32'h0, 32'h2, 32'h2, 32'h1};
	logic [31:0] rbaud[5] = '{32'h3, 32'h1, 32'h2, 32'h40002, 32'h0};
	logic [31:0] rexp[5] = '{32'h3, 32'h10, 32'h10, 32'h14, 32'h0};

	urt_rate_regs urt_rate_regs_inst (.clk(clk), .reset_n(reset_n), .address(address),
		.read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest), .card_clk_tick(card_clk_tick),
		.card_error(card_error), .char_load(char_load), .char_cmd_flag(char_cmd_flag),
		.rx_activity(rx_activity), .tx_char_done(tx_char_done), .baud_tick(baud_tick),
		.bit_tick(bit_tick), .delim_code(delim_code), .tx_hold(tx_hold),
		.ir_filter(ir_filter), .irq(irq));
	urt_far_end urt_far_end_inst (.clk(clk), .reset_n(reset_n), .card_run(card_run),
		.card_clk_tick(card_clk_tick), .card_error(card_error), .char_load(char_load),
		.char_cmd_flag(char_cmd_flag), .rx_activity(rx_activity),
		.tx_char_done(tx_char_done));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task final_report();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// one bus request held until waitrequest is sampled low, then a spare edge
	task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		int k;
		k = 0;
		address <= a;
		writedata <= d;
		write <= w;
		read <= ~w;
		@(posedge clk);
		while (waitrequest !== 1'b0 && k < 100) begin
			@(posedge clk);
			k++;
		end
		if (k >= 100) begin
			fails++;
			final_report();
		end
		rdata = readdata;
		read <= 1'b0;
		write <= 1'b0;
		@(posedge clk);
	endtask
	task wr(input logic [5:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task rdc(input string nm, input logic [5:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(nm, rdata, exp);
	endtask
	// clocks from one baud tick to the next; zero when no tick shows up
	task per(output logic [31:0] q);
		int k;
		k = 0;
		@(posedge clk);
		while (baud_tick !== 1'b1 && k < 300) begin
			@(posedge clk);
			k++;
		end
		k = 1;
		@(posedge clk);
		while (baud_tick !== 1'b1 && k < 300) begin
			@(posedge clk);
			k++;
		end
		q = (k < 300) ? k : 0;
		chk("bit_tick", {31'h0, bit_tick}, {31'h0, baud_tick});
	endtask
	// guard length: the high time of tx_hold after a finished character
	task guard(output int cnt);
		cnt = 0;
		urt_far_end_inst.end_char();
		repeat (40) @(posedge clk) if (tx_hold === 1'b1) cnt++;
	endtask
	// hang guard, far beyond the few thousand cycles the sequence needs
	initial begin
		#200000;
		fails++;
		final_report();
	end
	initial begin
		reset_n = 1'b0;
		address = 6'h00;
		read = 1'b0;
		write = 1'b0;
		writedata = 32'h0;
		byteenable = 4'hf;
		card_run = 1'b0;
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		chk("delim_rst", {30'h0, delim_code}, 32'h1);
		rdc("ratio_rst", OFS_RATIO, 32'h174);
		for (int i = 0; i < 5; i++) begin
			wr(wofs[i], 32'hffffffff);
			rdc("field_width", wofs[i], wexp[i]);
		end
		chk("ir_filter", {24'h0, ir_filter}, 32'hff);
		rdc("unmapped", 6'h3c, 32'h0);
		wr(OFS_MODE, 32'h4);
		urt_far_end_inst.send_errors(5);
		rdc("tally", OFS_ERRCNT, 32'h5);
		rdc("tally_clr", OFS_ERRCNT, 32'h0);
		for (int i = 0; i < 5; i++) begin
			wr(OFS_MODE, rmode[i]);
			wr(OFS_BAUD, rbaud[i]);
			per(p);
			per(p);
			chk("baud_period", p, rexp[i]);
		end
		// card mode: card clock edge every 2 clocks, ratio 3
		card_run <= 1'b1;
		wr(OFS_MODE, 32'h4);
		wr(OFS_BAUD, 32'h1);
		wr(OFS_RATIO, 32'h3);
		per(p);
		per(p);
		chk("card_period", p, 32'h6);
		wr(OFS_RATIO, 32'h0);
		per(p);
		chk("card_stopped", p, 32'h0);
		card_run <= 1'b0;
		urt_far_end_inst.load_char(1'b1);
		repeat (2) @(posedge clk);
		chk("delim_cmd", {30'h0, delim_code}, 32'h2);
		urt_far_end_inst.load_char(1'b0);
		repeat (2) @(posedge clk);
		chk("delim_data", {30'h0, delim_code}, 32'h1);
		// time-out: bit period 4 clocks, limit 5, so 20 clocks after arming
		wr(OFS_MODE, 32'h1);
		wr(OFS_BAUD, 32'h4);
		wr(OFS_RTO, 32'h5);
		wr(OFS_MASK, 32'h1);
		wr(OFS_CMD, 32'h1);
		rdc("to_early", OFS_STAT, 32'h0);
		repeat (30) @(posedge clk);
		rdc("to_set", OFS_STAT, 32'h1);
		chk("irq_on", {31'h0, irq}, 32'h1);
		wr(OFS_MASK, 32'h0);
		@(posedge clk);
		chk("irq_masked", {31'h0, irq}, 32'h0);
		wr(OFS_STAT, 32'h1);
		rdc("to_clr", OFS_STAT, 32'h0);
		wr(OFS_RTO, 32'h0);
		wr(OFS_CMD, 32'h1);
		repeat (40) @(posedge clk);
		rdc("to_off", OFS_STAT, 32'h0);
		// guard: bit period 2 clocks, gap 3, one clock of alignment slack
		wr(OFS_BAUD, 32'h2);
		wr(OFS_GUARD, 32'h3);
		guard(n);
		chk("guard_len", {31'h0, (n >= 5 && n <= 6)}, 32'h1);
		wr(OFS_GUARD, 32'h0);
		guard(n);
		chk("guard_off", n, 32'h0);
		final_report();
	end
endmodule
`default_nettype wire
